// >>> logic/rfc_consts.vh
/*
 rfc_consts.vh: register offsets, field positions, reset values and
 encodings for the rts flow control block.
 assumes: included by the design files of the rfc block only.
*/
`ifndef RFC_CONSTS_VH
`define RFC_CONSTS_VH

// apb register byte offsets
`define RFC_CTRL_OFF 12'h000
`define RFC_STAT_OFF 12'h004
`define RFC_FCTL_OFF 12'h008
`define RFC_LVL_OFF 12'h00c

// control register fields, one byte per channel (lane = channel)
`define RFC_SW_RTS_SEL_BIT 2
`define RFC_MCR_RTS_BIT 1
`define RFC_CTRL_RESET 8'h04

// fifo control fields
`define RFC_FIFO_EN_BIT 0
`define RFC_MODE_SEL_BIT 3
`define RFC_TRIG_LSB 6
`define RFC_FCTL_RESET 8'h00

// receive fifo depth and trigger levels
`define RFC_FIFO_DEPTH 16
`define RFC_TRIG_0 5'h01
`define RFC_TRIG_1 5'h04
`define RFC_TRIG_2 5'h08
`define RFC_TRIG_3 5'h0e

`endif

// >>> logic/rfc_chan.v
/*
 rfc_chan.v: one channel of receive-data-waiting tracking and rts gating.
 assumes: receiver fill level and timeout arrive synchronous to pclk;
 control bits come from the apb register file in rfc_top.
*/
`timescale 1ns/10ps
`include "rfc_consts.vh"

module rfc_chan #(
  parameter LVL_W = 5
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // receiver state
  input wire [LVL_W-1:0] rx_level,
  input wire char_timeout,
  // control
  input wire fifo_enable_bit,
  input wire rx_waiting_mode_select,
  input wire [1:0] trigger_sel,
  input wire software_only_rts_select,
  input wire mcr_rts,
  // results
  output reg receive_data_waiting,
  output reg rts_n
);

  reg [LVL_W-1:0] trig;
  reg next_waiting;
  reg next_rts_n;
  wire empty = (rx_level == {LVL_W{1'b0}});
  wire mode1 = fifo_enable_bit & rx_waiting_mode_select;

  always @* begin
    case (trigger_sel)
      2'd0: trig = `RFC_TRIG_0;
      2'd1: trig = `RFC_TRIG_1;
      2'd2: trig = `RFC_TRIG_2;
      default: trig = `RFC_TRIG_3;
    endcase
  end

  always @* begin
    next_waiting = receive_data_waiting;
    if (empty)
      next_waiting = 1'b0;
    else if (!mode1)
      next_waiting = 1'b1;
    else if (rx_level >= trig || char_timeout)
      next_waiting = 1'b1;
  end

  // rts is active low on the line; high here means deasserted
  always @* begin
    if (!mcr_rts)
      next_rts_n = 1'b1;
    else if (software_only_rts_select)
      next_rts_n = 1'b0;
    else
      next_rts_n = next_waiting;
  end

  // registered so the pin cannot glitch between terms
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_data_waiting <= 1'b0;
      rts_n <= 1'b1;
    end else begin
      receive_data_waiting <= next_waiting;
      rts_n <= next_rts_n;
    end
  end

endmodule

// >>> logic/rfc_top.v
/*
 rfc_top.v: rts hardware flow control for two serial channels, with
 an apb register file for the control bits.
 assumes: apb master per amba; receiver fill levels and timeouts are
 synchronous to pclk; the peripheral honours rts.
*/
`timescale 1ns/10ps
`include "rfc_consts.vh"

module rfc_top #(
  parameter NCH = 2,
  parameter LVL_W = 5
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // receiver state, one field per channel
  input wire [NCH*LVL_W-1:0] rx_level,
  input wire [NCH-1:0] char_timeout,
  // serial line
  output wire [NCH-1:0] rts_n
);

  reg [31:0] ctrl;
  reg [31:0] fctl;
  wire [NCH-1:0] waiting;
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `RFC_CTRL_OFF);
  wire hit_stat = (paddr == `RFC_STAT_OFF);
  wire hit_fctl = (paddr == `RFC_FCTL_OFF);
  wire hit_lvl = (paddr == `RFC_LVL_OFF);
  wire mapped = hit_ctrl | hit_stat | hit_fctl | hit_lvl;
  integer i;

  // zero wait state slave; unmapped addresses give an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= {4{`RFC_CTRL_RESET}};
      fctl <= {4{`RFC_FCTL_RESET}};
    end else if (wr) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (pstrb[i] && hit_ctrl)
          ctrl[i*8 +: 8] <= pwdata[i*8 +: 8];
        if (pstrb[i] && hit_fctl)
          fctl[i*8 +: 8] <= pwdata[i*8 +: 8];
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      rfc_chan #(
        .LVL_W(LVL_W)
      ) u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .rx_level(rx_level[c*LVL_W +: LVL_W]),
        .char_timeout(char_timeout[c]),
        .fifo_enable_bit(fctl[c*8 + `RFC_FIFO_EN_BIT]),
        .rx_waiting_mode_select(fctl[c*8 + `RFC_MODE_SEL_BIT]),
        .trigger_sel(fctl[c*8 + `RFC_TRIG_LSB +: 2]),
        .software_only_rts_select(ctrl[c*8 + `RFC_SW_RTS_SEL_BIT]),
        .mcr_rts(ctrl[c*8 + `RFC_MCR_RTS_BIT]),
        .receive_data_waiting(waiting[c]),
        .rts_n(rts_n[c])
      );
    end
  endgenerate

  // read data registered in the setup cycle, valid in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit_ctrl)
        prdata <= ctrl;
      else if (hit_fctl)
        prdata <= fctl;
      else if (hit_stat) begin
        for (i = 0; i < NCH; i = i + 1) begin
          prdata[i] <= waiting[i];
          prdata[8 + i] <= ~rts_n[i];
        end
      end else if (hit_lvl) begin
        for (i = 0; i < NCH; i = i + 1)
          prdata[i*8 +: LVL_W] <= rx_level[i*LVL_W +: LVL_W];
      end
    end
  end

endmodule

// >>> verification/rfc_chk.sv
/* rts gating checks on channel 0.
 assumes: bound to rfc_top ports. */
`timescale 1ns/10ps
module rfc_chk #(parameter NCH=2, parameter LVL_W=5) (
  input wire pclk, presetn, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [NCH*LVL_W-1:0] rx_level,
  input wire [NCH-1:0] char_timeout, rts_n);
  // shadow of lane 0 controls, tracked from apb writes
  reg [7:0] c, f;
  wire wr = psel & penable & pwrite;
  wire hw = c[1] & !c[2];
  wire m1 = f[0] & f[3];
  wire [4:0] l = rx_level[4:0];
  wire t = char_timeout[0];
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      c <= 8'h04;
      f <= 8'h00;
    end else if (wr & paddr == 12'h000) c <= pwdata[7:0];
    else if (wr & paddr == 12'h008) f <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mcr_off: assert property (!c[1] |=> rts_n[0])
    else $error("rts on, modem bit off");
  a_sw_only: assert property (c[1] & c[2] |=> !rts_n[0])
    else $error("rts off in software mode");
  a_any_char: assert property (hw & !m1 & l != 0 |=> rts_n[0])
    else $error("rts on with char held");
  a_trig_max: assert property (hw & m1 & l >= 14 |=> rts_n[0])
    else $error("rts on at top trigger");
  a_timeout: assert property (hw & m1 & t & l != 0 |=> rts_n[0])
    else $error("rts on after timeout");
  a_below_trig: assert property (hw & $past(hw) & !rts_n[0] & m1
    & f[7:6] == 2'h3 & l < 14 & !t |=> !rts_n[0])
    else $error("rts off below trigger");
  a_hold_full: assert property (hw & $past(hw) & rts_n[0] & l != 0
    |=> rts_n[0]) else $error("rts back before empty");
  a_reassert: assert property (hw & l == 0 |=> !rts_n[0])
    else $error("rts off when empty");
  cover property (hw & rts_n[0]);
  cover property (m1 & t & l != 0);
  cover property (c[2] & c[1] & l != 0);
endmodule
bind rfc_top rfc_chk #(.NCH(NCH), .LVL_W(LVL_W)) rfc_chk_inst (.*);

// >>> verification/rfc_peer.sv
/* peripheral model: one char a cycle while rts asserted.
 assumes: drain stands for the cpu emptying the fifo. */
`timescale 1ns/10ps
module rfc_peer (
  input wire pclk, presetn, rts_n, drain,
  output reg [4:0] lvl);
  always @(posedge pclk or negedge presetn)
    if (!presetn) lvl <= 5'h00;
    else if (drain) lvl <= 5'h00;
    else if (!rts_n & lvl < 5'h10) lvl <= lvl + 5'h01;
endmodule

// >>> verification/rfc_top_bench.sv
/* bench for rfc_top: apb master, peer on channel 0, read queue.
 assumes: rfc_top, rfc_peer and rfc_chk compiled. */
`timescale 1ns/10ps
module rfc_top_bench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drain = 1;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [4:0] l1 = 0;
  reg [1:0] char_timeout = 0;
  wire pready, pslverr;
  wire [31:0] prdata;
  wire [1:0] rts_n;
  wire [4:0] l0;
  wire [3:0] pstrb = 4'hf;
  wire [9:0] rx_level = {l1, l0};
  logic [32:0] q[$];
  integer n_errors = 0, total_checks = 0, cyc = 0, i;
  // {timeout, fifo control, final channel 0 level}
  logic [15:0] tb[7] = '{16'h0002, 16'h0012, 16'h0092, 16'h0495,
    16'h0899, 16'h0c9f, 16'h1c92};
  rfc_top rfc_top_inst (.*);
  rfc_peer rfc_peer_inst (.pclk, .presetn, .rts_n(rts_n[0]), .drain,
    .lvl(l0));
  initial forever #12.5 pclk = ~pclk;
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input [11:0] a, input [32:0] e);
    q.push_back(e);
    xfer(0, a, 0);
  endtask
  function [32:0] st(input w0, a0, w1, a1);
    st = {23'h0, a1, a0, 6'h0, w1, w0};
  endfunction
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel & penable & !pwrite & pready) begin
      total_checks++;
      if ({pslverr, prdata} !== q[0]) begin
        n_errors++;
        $display("Error %0t: %h vs %h", $time, {pslverr, prdata}, q[0]);
      end
      void'(q.pop_front());
    end
    if (cyc == 3000) begin
      n_errors++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(40));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(12'h000, 33'h004040404);
    rd(12'h010, 33'h100000000);
    rd(12'h004, st(0, 0, 0, 0));
    xfer(1, 12'h000, 32'h02020202);
    for (i = 0; i < 7; i++) begin
      drain <= 1;
      repeat (3) @(posedge pclk);
      rd(12'h004, st(0, 1, l1 != 0, l1 == 0));
      l1 <= $urandom % 17;
      xfer(1, 12'h008, {24'h0, tb[i][11:4]});
      char_timeout <= {1'($urandom), tb[i][12]};
      drain <= 0;
      repeat (40) @(posedge pclk);
      rd(12'h00c, {20'h0, l1, 4'h0, tb[i][3:0]});
      rd(12'h004, st(1, 0, l1 != 0, l1 == 0));
      $display("test %0d done", i);
    end
    xfer(1, 12'h000, 32'h06060606);
    rd(12'h004, st(1, 1, l1 != 0, 1));
    give_verdict;
  end
endmodule
